/* File: core/ldc_serial_ctrl.sv */
// Serial command interpreter and display memory for the LED display controller
`timescale 1ns/1ps
module ldc_serial_ctrl
  import ldc_pkg::*;
#(
  parameter int FRAME_CYC = LDC_FRAME_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        serialSelectStrobe,
  input  wire logic        shiftClk,
  input  wire logic        dataIn,
  output logic             dataOut,
  output logic             dataOutEn_b,
  input  wire logic [1:0]  keyReturnInputs,
  output logic      [9:0]  keySourceLine,
  output logic      [1:0]  displayMode,
  output logic             displayOn,
  output logic      [2:0]  pulseWidth,
  output logic      [3:0]  memAddr,
  output logic      [7:0]  memRdData,
  input  wire logic [3:0]  memRdAddr,
  output logic             scanDone
);
  import ldc_pkg::*;

  typedef enum logic [2:0] {
    LDC_IDLE = 3'b001,
    LDC_RECV = 3'b010,
    LDC_SEND = 3'b100
  } ldc_state_e;

  ldc_state_e  stateReg;
  logic [2:0]  stbSyncReg;
  logic [2:0]  clkSyncReg;
  logic [1:0]  dinSyncReg;
  logic [7:0]  shiftReg;
  logic [2:0]  bitCntReg;
  logic        firstByteReg;
  logic        autoIncReg;
  logic        readModeReg;
  logic [7:0]  mem [LDC_MEM_DEPTH];
  logic [23:0] keyData;
  logic [4:0]  rdBitReg;
  logic        outBitReg;
  logic        stbHigh;
  logic        clkRise;
  logic        clkFall;
  logic        byteDone;
  logic [7:0]  rxByte;

  // Third stage is only an edge history
  always_ff @(posedge mclk) begin
    stbSyncReg <= {stbSyncReg[1:0], serialSelectStrobe};
    clkSyncReg <= {clkSyncReg[1:0], shiftClk};
    dinSyncReg <= {dinSyncReg[0], dataIn};
  end

  assign stbHigh  = stbSyncReg[1];
  assign clkRise  = !stbHigh && clkSyncReg[1] && !clkSyncReg[2]; // RULE14
  assign clkFall  = !stbHigh && !clkSyncReg[1] && clkSyncReg[2];
  assign rxByte   = {dinSyncReg[1], shiftReg[7:1]};
  assign byteDone = clkRise && stateReg == LDC_RECV && bitCntReg == 3'h7;

  // LSB first shift on rising edge
  always_ff @(posedge mclk) begin
    if (!rst_b || stbHigh) begin // RULE11
      stateReg     <= LDC_IDLE;
      bitCntReg    <= '0;
      shiftReg     <= '0;
      firstByteReg <= 1'b1;
    end else begin
      case (stateReg)
        LDC_IDLE: begin
          stateReg <= LDC_RECV;
        end
        LDC_RECV: begin
          if (clkRise) begin // RULE13
            shiftReg  <= rxByte;
            bitCntReg <= bitCntReg + 3'h1;
            if (bitCntReg == 3'h7) begin
              firstByteReg <= 1'b0; // RULE10
              if (firstByteReg && rxByte[7:6] == LDC_CMD_DATA && rxByte[1:0] == LDC_DS_READ) begin
                stateReg <= LDC_SEND;
              end
            end
          end
        end
        LDC_SEND: begin
          stateReg <= LDC_SEND;
        end
        default: stateReg <= LDC_IDLE;
      endcase
    end
  end

  // Command decode on the first byte of each strobe frame
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      displayMode <= LDC_MODE_RESET;
      displayOn   <= 1'b0; // RULE1
      pulseWidth  <= LDC_PW_RESET; // RULE1
      autoIncReg  <= 1'b1;
      readModeReg <= 1'b0;
      memAddr     <= '0;
    end else if (byteDone) begin
      if (firstByteReg) begin // RULE10
        case (rxByte[7:6])
          LDC_CMD_MODE: displayMode <= rxByte[1:0];
          LDC_CMD_DATA: begin
            readModeReg <= rxByte[1];
            autoIncReg  <= !rxByte[2];
          end
          LDC_CMD_CTRL: begin
            displayOn  <= rxByte[3]; // RULE9
            pulseWidth <= rxByte[2:0];
          end
          default: memAddr <= rxByte[3:0];
        endcase
      end else if (!readModeReg && memAddr <= LDC_ADDR_MAX && autoIncReg) begin // RULE12
        memAddr <= memAddr + 4'h1; // RULE5
      end
    end
  end

  // Writes land only inside the valid range
  always_ff @(posedge mclk) begin
    if (byteDone && !firstByteReg && !readModeReg && memAddr <= LDC_ADDR_MAX) begin // RULE12
      mem[memAddr] <= rxByte; // RULE7
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      memRdData <= '0;
    end else if (memRdAddr <= LDC_ADDR_MAX) begin
      memRdData <= mem[memRdAddr];
    end else begin
      memRdData <= '0;
    end
  end

  // Read data shifts out on falling edges, LSB first
  always_ff @(posedge mclk) begin
    if (!rst_b || stbHigh) begin
      rdBitReg  <= '0;
      outBitReg <= 1'b1; // RULE14
    end else if (stateReg == LDC_SEND && clkFall) begin // RULE13
      outBitReg <= keyData[rdBitReg];
      rdBitReg  <= (rdBitReg == 5'h17) ? 5'h00 : rdBitReg + 5'h01;
    end
  end

  assign dataOut     = 1'b0;
  assign dataOutEn_b = !(stateReg == LDC_SEND && !outBitReg);

  ldc_key_scan #(
    .FRAME_CYC(FRAME_CYC)
  ) uScan (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .keyReturnInputs (keyReturnInputs),
    .keySourceLine   (keySourceLine),
    .keyData         (keyData),
    .scanDone        (scanDone)
  );
endmodule // ldc_serial_ctrl

/* File: core/ldc_pkg.sv */
// Constants shared by the LED display serial command controller
// Contract
// RULE1 - At power-up the pulse width is one sixteenth, the display is off and key scanning runs.
// RULE2 - One key-scan cycle spans exactly two display frames and samples the key returns in it.
// RULE3 - Scanned key results are stored in key data memory for a later read command.
// RULE4 - The host waits at least one microsecond after the eighth clock before the first read clock.
// RULE5 - An incrementing update is mode, data, address, display bytes, control; address advances.
// RULE6 - The host sends no more than fourteen display bytes in one incrementing burst.
// RULE7 - A fixed-address update writes its single byte to the addressed location only.
// RULE8 - The host should clear all display memory during initial setup.
// RULE9 - Display control byte 80h turns the display off.
// RULE10 - The first byte after the strobe falls is a command, bits b0 to b7.
// RULE11 - Strobe rising mid-transfer resets the serial logic and discards the partial byte.
// RULE12 - Only addresses 00h to 0Dh are valid; data is ignored after an invalid address is set.
// RULE13 - Input is sampled on the rising shift-clock edge and output changes on the falling edge.
// RULE14 - While the strobe is high shift-clock activity is ignored and the output is released.
package ldc_pkg;
  localparam int          LDC_MEM_DEPTH     = 14;
  localparam logic [3:0]  LDC_ADDR_MAX      = 4'hD;
  localparam logic [2:0]  LDC_PW_RESET      = 3'h0;
  localparam logic [1:0]  LDC_MODE_RESET    = 2'h3;
  localparam logic [1:0]  LDC_CMD_MODE      = 2'h0;
  localparam logic [1:0]  LDC_CMD_DATA      = 2'h1;
  localparam logic [1:0]  LDC_CMD_CTRL      = 2'h2;
  localparam logic [1:0]  LDC_CMD_ADDR      = 2'h3;
  localparam logic [1:0]  LDC_DS_WRITE      = 2'h0;
  localparam logic [1:0]  LDC_DS_READ       = 2'h2;
  localparam int          LDC_KEY_BYTES     = 3;
  localparam int          LDC_KEY_SOURCES   = 10;
  localparam int          LDC_FRAMES_PER_SCAN = 2;
  localparam int          LDC_CLK_MHZ       = 125;
  localparam int          LDC_FRAME_NS      = 16000;
  localparam int          LDC_FRAME_CYC     = LDC_FRAME_NS * LDC_CLK_MHZ / 1000;
  localparam int          LDC_SLOT_CYC      = LDC_FRAME_CYC / LDC_KEY_SOURCES;
  localparam int          LDC_TWAIT_NS      = 1000;
  localparam int          LDC_TWAIT_CYC     = (LDC_TWAIT_NS * LDC_CLK_MHZ + 999) / 1000;
endpackage

/* File: core/ldc_key_scan.sv */
// Key source sequencer and key data store
`timescale 1ns/1ps
module ldc_key_scan
  import ldc_pkg::*;
#(
  parameter int FRAME_CYC = LDC_FRAME_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  keyReturnInputs,
  output logic      [9:0]  keySourceLine,
  output logic      [23:0] keyData,
  output logic             scanDone
);
  localparam int SLOT = FRAME_CYC / LDC_KEY_SOURCES;
  localparam int SW   = $clog2(SLOT + 1);

  logic [1:0]    kSync1Reg;
  logic [1:0]    kSync2Reg;
  logic [SW-1:0] slotCntReg;
  logic [3:0]    srcReg;
  logic          frameReg;
  logic [19:0]   hitReg;

  always_ff @(posedge mclk) begin
    kSync1Reg <= keyReturnInputs;
    kSync2Reg <= kSync1Reg;
  end

  // Two frames of ten slots make one scan cycle
  always_ff @(posedge mclk) begin
    scanDone <= 1'b0;
    if (!rst_b) begin
      slotCntReg <= '0;
      srcReg     <= '0;
      frameReg   <= 1'b0;
    end else if (slotCntReg == SW'(SLOT - 1)) begin
      slotCntReg <= '0;
      if (srcReg == 4'(LDC_KEY_SOURCES - 1)) begin
        srcReg   <= '0;
        frameReg <= ~frameReg;
        scanDone <= frameReg; // RULE2
      end else begin
        srcReg <= srcReg + 4'h1;
      end
    end else begin
      slotCntReg <= slotCntReg + SW'(1);
    end
  end

  // Sample returns late in the slot, second frame only; scanning starts at reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hitReg  <= '0;
      keyData <= '0;
    end else begin
      if (frameReg && slotCntReg == SW'(SLOT - 2)) begin // RULE2
        hitReg[2*srcReg +: 2] <= kSync2Reg;
      end
      if (frameReg && srcReg == 4'(LDC_KEY_SOURCES - 1) && slotCntReg == SW'(SLOT - 1)) begin
        for (int i = 0; i < 5; i++) begin // RULE3
          keyData[8*(i/2) + 4*(i%2) +: 2] <= hitReg[4*i +: 2];
          keyData[8*(i/2) + 4*(i%2) + 2 +: 2] <= hitReg[4*i+2 +: 2];
        end
      end
    end
  end

  assign keySourceLine = rst_b ? (10'h001 << srcReg) : 10'h000;
endmodule // ldc_key_scan

/* File: sim/ldc_serial_ctrl_properties.sv */
// Port checks for the serial command controller
`timescale 1ns/1ps
module ldc_serial_ctrl_properties
  import ldc_pkg::*;
#(
  parameter int FRAME_CYC = LDC_FRAME_CYC
) (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       serialSelectStrobe,
  input wire logic       dataOutEn_b,
  input wire logic [9:0] keySourceLine,
  input wire logic       displayOn,
  input wire logic [2:0] pulseWidth,
  input wire logic [3:0] memAddr,
  input wire logic [7:0] memRdData,
  input wire logic [3:0] memRdAddr,
  input wire logic       scanDone
);
  localparam int SCAN_CYC = 2 * FRAME_CYC;
  int   gapCntReg;
  logic seenScanReg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Counter stands in for a scan period longer than a plain delay may be
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gapCntReg   <= 0;
      seenScanReg <= 1'b0;
    end else if (scanDone) begin
      gapCntReg   <= 0;
      seenScanReg <= 1'b1;
    end else if (gapCntReg < SCAN_CYC) begin
      gapCntReg <= gapCntReg + 1;
    end
  end
  // Six cycles covers the strobe synchroniser
  sequence strobeIdle;
    serialSelectStrobe [*6];
  endsequence
  reset_defaults_a: assert property ($rose(rst_b) |-> !displayOn && pulseWidth == LDC_PW_RESET)
    else $error("display defaults wrong");
  addr_default_a: assert property ($rose(rst_b) |-> memAddr == 4'h0)
    else $error("address not zero");
  scan_onehot_a: assert property ($past(rst_b, 2) |-> $onehot(keySourceLine))
    else $error("key source not one-hot");
  scan_period_a: assert property (seenScanReg |-> (scanDone == (gapCntReg == SCAN_CYC - 1)))
    else $error("scan period wrong");
  scan_pulse_a: assert property (scanDone |=> !scanDone [*8])
    else $error("scan done too long");
  out_released_a: assert property (strobeIdle |-> dataOutEn_b)
    else $error("output driven while idle");
  regs_hold_a: assert property (strobeIdle |=> $stable(memAddr) && $stable({displayOn, pulseWidth}))
    else $error("state moved while idle");
  rd_range_a: assert property (memRdAddr > LDC_ADDR_MAX |=> memRdData == 8'h00)
    else $error("read beyond memory not zero");
endmodule // ldc_serial_ctrl_properties
bind ldc_serial_ctrl ldc_serial_ctrl_properties #(.FRAME_CYC(FRAME_CYC)) prop_u (
  .mclk(mclk), .rst_b(rst_b), .serialSelectStrobe(serialSelectStrobe),
  .dataOutEn_b(dataOutEn_b), .keySourceLine(keySourceLine), .displayOn(displayOn),
  .pulseWidth(pulseWidth), .memAddr(memAddr), .memRdData(memRdData),
  .memRdAddr(memRdAddr), .scanDone(scanDone));

/* File: sim/ldc_host_model.sv */
// Host side of the strobed serial link
`timescale 1ns/1ps
module ldc_host_model
  import ldc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic lineLvl,
  output logic      serialSelectStrobe,
  output logic      shiftClk,
  output logic      dataIn
);
  initial begin
    serialSelectStrobe = 1'b1;
    shiftClk = 1'b1;
    dataIn = 1'b0;
  end
  // Half of a 160 ns link period
  task automatic half();
    repeat (10) @(posedge mclk);
    #1;
  endtask
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      shiftClk = 1'b0;
      dataIn = b[i];
      half();
      shiftClk = 1'b1;
      half();
    end
  endtask
  task automatic frame(input logic [7:0] q[$], input int lastBits = 8);
    serialSelectStrobe = 1'b0;
    half();
    foreach (q[i]) put(q[i], (i == q.size() - 1) ? lastBits : 8);
    serialSelectStrobe = 1'b1;
    // Released line must not keep the last bit
    dataIn = ~dataIn;
    half();
  endtask
  task automatic readKeys(output logic [23:0] k);
    serialSelectStrobe = 1'b0;
    half();
    put(8'h42, 8);
    repeat (LDC_TWAIT_CYC + 4) @(posedge mclk);
    #1;
    for (int i = 0; i < 24; i++) begin
      shiftClk = 1'b0;
      dataIn = ~dataIn;
      half();
      shiftClk = 1'b1;
      k[i] = lineLvl;
      half();
    end
    serialSelectStrobe = 1'b1;
    half();
  endtask
endmodule // ldc_host_model

/* File: sim/ldc_serial_ctrl_tb.sv */
// Random and directed bench for the serial command controller
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h seen %h", nm, e, s); end end
module ldc_serial_ctrl_tb;
  import ldc_pkg::*;
  localparam int FRAME = 100;
  logic        mclk, rst_b, dataOut, dataOutEn_b, displayOn, scanDone, lineLvl;
  logic        serialSelectStrobe, shiftClk, dataIn;
  logic [1:0]  keyReturnInputs, displayMode;
  logic [9:0]  keySourceLine;
  logic [2:0]  pulseWidth;
  logic [3:0]  memAddr, memRdAddr;
  logic [7:0]  memRdData, expMem[16], q[$];
  logic [23:0] keys;
  logic [31:0] seed;
  int          err_count, n_tests, cycles;
  // Pull-up on the open-drain line
  assign lineLvl = dataOutEn_b ? 1'b1 : dataOut;
  ldc_serial_ctrl #(.FRAME_CYC(FRAME)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .serialSelectStrobe(serialSelectStrobe), .shiftClk(shiftClk),
    .dataIn(dataIn), .dataOut(dataOut), .dataOutEn_b(dataOutEn_b),
    .keyReturnInputs(keyReturnInputs), .keySourceLine(keySourceLine),
    .displayMode(displayMode), .displayOn(displayOn), .pulseWidth(pulseWidth),
    .memAddr(memAddr), .memRdData(memRdData), .memRdAddr(memRdAddr), .scanDone(scanDone));
  ldc_host_model host_u (.mclk(mclk), .lineLvl(lineLvl), .serialSelectStrobe(serialSelectStrobe),
    .shiftClk(shiftClk), .dataIn(dataIn));
  // Ten sources of two returns each, top nibble unused
  function automatic logic [23:0] keyWord(input logic [1:0] k);
    return {4'h0, {10{k}}};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chkMem();
    for (int i = 0; i < 16; i++) begin
      memRdAddr = i[3:0];
      repeat (2) @(posedge mclk);
      #1;
      `CHK("memRdData", expMem[i], memRdData)
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0;
    keyReturnInputs = 2'h0;
    memRdAddr = 4'h0;
    seed = 32'he099_f161;
    for (int i = 0; i < 16; i++) expMem[i] = 8'h00;
    repeat (20) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    @(posedge mclk);
    #1;
    `CHK("displayOn", 1'b0, displayOn)
    `CHK("pulseWidth", LDC_PW_RESET, pulseWidth)
    keyReturnInputs = seed[1:0];
    host_u.frame('{8'h02});
    host_u.frame('{8'h40});
    q = '{8'hC0};
    for (int i = 0; i < LDC_MEM_DEPTH; i++) q.push_back(8'h00);
    host_u.frame(q);
    q = '{8'hC0};
    for (int i = 0; i < LDC_MEM_DEPTH; i++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      expMem[i] = seed[7:0];
    end
    host_u.frame(q);
    host_u.frame('{8'h8F});
    `CHK("displayMode", 2'h2, displayMode)
    `CHK("ctrl", 4'hF, {displayOn, pulseWidth})
    chkMem();
    host_u.frame('{8'h44});
    seed = lfsr(seed);
    host_u.frame('{8'hC5, seed[7:0]});
    expMem[5] = seed[7:0];
    chkMem();
    host_u.frame('{8'hCE, 8'hA5});
    chkMem();
    // Incrementing from an invalid address must not wrap back to zero
    host_u.frame('{8'h40});
    host_u.frame('{8'hCF, 8'hA5, 8'h5A});
    `CHK("memAddr", 4'hF, memAddr)
    chkMem();
    // A partial off command, then a full one that would finish it if kept
    host_u.frame('{8'h80}, 7);
    `CHK("ctrl", 4'hF, {displayOn, pulseWidth})
    host_u.frame('{8'h8D});
    `CHK("ctrl", 4'hD, {displayOn, pulseWidth})
    host_u.frame('{8'h80});
    `CHK("displayOn", 1'b0, displayOn)
    `CHK("ctrl", 4'h0, {displayOn, pulseWidth})
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      keyReturnInputs = (r == 0) ? 2'h0 : ((r == 1) ? 2'h3 : seed[1:0]);
      repeat (4 * FRAME + 20) @(posedge mclk);
      #1;
      host_u.readKeys(keys);
      `CHK("keys", keyWord(keyReturnInputs), keys)
    end
    final_report();
  end
endmodule // ldc_serial_ctrl_tb
